// file: shared/disk_port_pkg.sv
/*
 Constants, types and helpers for the fixed disk host port.
 Assumes an 8-bit I/O bus on the system clock and a controller core
 behind the port that runs commands and moves record bytes.
*/
// Behaviour
// - Host sees three readable 8-bit registers: status, data and control.
// - Status register reads current state at any time.
// - Status is read-only; host paces data bytes by its bits.
// - One data port fronts a stack of internal registers.
// - Command bytes written in order, results read in order.
// - Write to port 322h issues a controller-select pulse.
// - Record bytes move through system DMA requests.
// - Interrupt raised on completion, once the status byte waits.
// - 32-bit ECC protects record data against burst errors.
// - One or two drives share one daisy-chained cable.
// - Completion byte: bit 1 error, bit 5 unit, rest zero.
// - Interrupt when status byte ready; busy drops once read.
// - After an error status, four sense bytes follow.
package disk_port_pkg;
   localparam int ADDR_W = 10;
   localparam logic [9:0] PORT_DATA = 10'h320;
   localparam logic [9:0] PORT_STAT = 10'h321;
   localparam logic [9:0] PORT_SEL = 10'h322;
   localparam logic [9:0] PORT_CTRL = 10'h323;
   localparam int CMD_BYTES = 6;
   localparam int SENSE_BYTES = 4;
   // Status register fields
   localparam int ST_REQ = 0;
   localparam int ST_DIR = 1;
   localparam int ST_CMD = 2;
   localparam int ST_BUSY = 3;
   localparam int ST_IRQ = 4;
   localparam int ST_DRQ = 5;
   // Control register fields
   localparam int CT_IRQ_EN = 0;
   localparam int CT_DMA_EN = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;
   // Completion byte fields, command unit bit, sense code and ECC constants
   localparam int CB_ERR = 1;
   localparam int CB_LUN = 5;
   localparam int CMD_LUN_BIT = 37;
   localparam logic [7:0] SENSE_DATA_ERR = 8'h11;
   localparam logic [31:0] ECC_POLY = 32'h04C11DB7;
   localparam logic [31:0] ECC_INIT = 32'h00000000;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_CMDIN = 5'h02,
      ST_WAIT = 5'h04,
      ST_XFER = 5'h08,
      ST_STATB = 5'h10
   } port_state_e;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } io_req_s;

   typedef struct packed {
      logic err;
      logic [31:0] ecc;
      logic [31:0] sense;
   } core_done_s;

   function automatic logic [31:0] ecc_step(input logic [31:0] c,
                                            input logic [7:0] b);
      logic [31:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = (r[31] ^ b[i]) ? ((r << 1) ^ ECC_POLY) : (r << 1);
      end
      return r;
   endfunction
endpackage

// file: rtl/disk_host_port.sv
/*
 Host-facing register port of the fixed disk adapter: status and
 data ports, select pulse, DMA request, interrupt and record ECC.
 Assumes bus strobes are synchronous to sys_clk_i and last one cycle.
*/
`timescale 1ns/1ns
module disk_host_port (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire disk_port_pkg::io_req_s io_i,
   output logic [7:0] io_rdata_o,
   input wire logic dack_i,
   input wire logic tc_i,
   output logic drq_o,
   output logic irq_o,
   output logic ctl_sel_o,
   output logic cmd_go_o,
   output logic [8*disk_port_pkg::CMD_BYTES-1:0] cmd_o,
   input wire logic core_xfer_i,
   input wire logic core_dir_i,
   input wire logic core_done_i,
   input wire disk_port_pkg::core_done_s core_res_i,
   input wire logic rec_in_valid_i,
   input wire logic [7:0] rec_in_data_i,
   output logic rec_in_ready_o,
   output logic rec_out_valid_o,
   output logic [7:0] rec_out_data_o,
   input wire logic rec_out_ready_i,
   output logic [31:0] ecc_o,
   output logic [1:0] drive_sel_o
);
   import disk_port_pkg::*;

   function automatic logic hit(input io_req_s r, input logic [9:0] a);
      return !dack_i && r.addr == a;
   endfunction

   port_state_e state_q, state_d;
   logic [2:0] cnt_q, cnt_d;
   logic [8*CMD_BYTES-1:0] cmd_q, cmd_d;
   logic [1:0] ctrl_q, ctrl_d;
   logic busy_q, busy_d;
   logic sense_q, sense_d;
   logic dir_q, dir_d;
   logic err_q, err_d;
   logic [31:0] sense_bytes_q, sense_bytes_d;
   logic [7:0] rec_q, rec_d;
   logic full_q, full_d;
   logic tc_seen_q, tc_seen_d;
   logic [31:0] ecc_q, ecc_d;
   logic [7:0] rdata_q, rdata_d;
   logic sel_q, sel_d, go_q, go_d, irq_q, irq_d;
   logic [7:0] status_w, compl_w;
   logic rd_data, wr_data, lun;

   assign lun = cmd_q[CMD_LUN_BIT];
   assign rd_data = io_i.rd && hit(io_i, PORT_DATA);
   assign wr_data = io_i.wr && hit(io_i, PORT_DATA);
   // Completion byte: only error and unit bits may be set
   assign compl_w = 8'(err_q) << CB_ERR | 8'(lun) << CB_LUN;

   // Pacing bits for programmed transfers
   always_comb begin
      status_w = 8'h00;
      status_w[ST_REQ] = state_q == ST_CMDIN || state_q == ST_STATB;
      status_w[ST_DIR] = state_q == ST_STATB;
      status_w[ST_CMD] = state_q == ST_CMDIN;
      status_w[ST_BUSY] = busy_q;
      status_w[ST_IRQ] = irq_q;
      status_w[ST_DRQ] = drq_o;
   end

   // DMA request while a record byte can move
   assign drq_o = state_q == ST_XFER && ctrl_q[CT_DMA_EN] && !tc_seen_q
                  && (dir_q ? full_q : !full_q);
   assign rec_in_ready_o = state_q == ST_XFER && dir_q && !full_q;
   assign rec_out_valid_o = !dir_q && full_q;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      cmd_d = cmd_q;
      ctrl_d = ctrl_q;
      busy_d = busy_q;
      sense_d = sense_q;
      dir_d = dir_q;
      err_d = err_q;
      sense_bytes_d = sense_bytes_q;
      rec_d = rec_q;
      full_d = full_q;
      tc_seen_d = tc_seen_q;
      ecc_d = ecc_q;
      rdata_d = rdata_q;
      sel_d = 1'b0;
      go_d = 1'b0;
      // Writes to the status port fall through untouched
      if (io_i.wr && hit(io_i, PORT_CTRL)) begin
         ctrl_d = io_i.wdata[1:0];
      end
      if (io_i.rd) begin
         rdata_d = 8'h00;
         if (hit(io_i, PORT_STAT)) begin
            rdata_d = status_w;
         end else if (hit(io_i, PORT_CTRL)) begin
            rdata_d = {6'h00, ctrl_q};
         end
      end
      // Select pulse restarts the command phase
      if (io_i.wr && hit(io_i, PORT_SEL)) begin
         sel_d = 1'b1;
         state_d = ST_CMDIN;
         cnt_d = 3'h0;
         busy_d = 1'b1;
         sense_d = 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               // Sense bytes stay readable after busy has dropped
               if (rd_data && sense_q) begin
                  rdata_d = sense_bytes_q[8*(3-cnt_q[1:0]) +: 8];
                  cnt_d = cnt_q + 3'h1;
                  if (cnt_q == 3'(SENSE_BYTES - 1)) begin
                     sense_d = 1'b0;
                  end
               end
            end
            ST_CMDIN: begin
               if (wr_data) begin
                  cmd_d[8*(CMD_BYTES-1-int'(cnt_q)) +: 8] = io_i.wdata;
                  cnt_d = cnt_q + 3'h1;
                  if (cnt_q == 3'(CMD_BYTES - 1)) begin
                     go_d = 1'b1;
                     state_d = ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               if (core_done_i) begin
                  state_d = ST_STATB;
                  err_d = core_res_i.err;
                  sense_bytes_d = core_res_i.sense;
               end else if (core_xfer_i) begin
                  state_d = ST_XFER;
                  dir_d = core_dir_i;
                  full_d = 1'b0;
                  tc_seen_d = 1'b0;
                  ecc_d = ECC_INIT;
               end
            end
            ST_XFER: begin
               // Count end stops requests for the rest of the record phase
               if (dack_i && tc_i) begin
                  tc_seen_d = 1'b1;
               end
               if (dir_q) begin
                  if (dack_i && io_i.rd) begin
                     rdata_d = rec_q;
                     full_d = 1'b0;
                  end
                  if (rec_in_valid_i && rec_in_ready_o) begin
                     rec_d = rec_in_data_i;
                     full_d = 1'b1;
                     ecc_d = ecc_step(ecc_q, rec_in_data_i);
                  end
               end else begin
                  if (rec_out_ready_i && full_q) begin
                     full_d = 1'b0;
                  end
                  if (dack_i && io_i.wr && !full_q) begin
                     rec_d = io_i.wdata;
                     full_d = 1'b1;
                     ecc_d = ecc_step(ecc_q, io_i.wdata);
                  end
               end
               if (core_done_i) begin
                  state_d = ST_STATB;
                  sense_bytes_d = core_res_i.sense;
                  err_d = core_res_i.err;
                  // Check code mismatch on read-back flags a data error
                  if (dir_q && core_res_i.ecc != ecc_q) begin
                     err_d = 1'b1;
                     sense_bytes_d[31:24] = SENSE_DATA_ERR;
                  end
               end
            end
            ST_STATB: begin
               if (rd_data) begin
                  rdata_d = compl_w;
                  busy_d = 1'b0;
                  state_d = ST_IDLE;
                  sense_d = err_q;
                  cnt_d = 3'h0;
               end
            end
         endcase
      end
      // Raised once the completion byte waits
      // Uses the new enable so a late write still raises the line
      irq_d = ctrl_d[CT_IRQ_EN] && state_d == ST_STATB;
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         state_q <= ST_IDLE;
         cnt_q <= 3'h0;
         cmd_q <= '0;
         ctrl_q <= CTRL_RST;
         busy_q <= 1'b0;
         sense_q <= 1'b0;
         dir_q <= 1'b0;
         err_q <= 1'b0;
         sense_bytes_q <= '0;
         rec_q <= 8'h00;
         full_q <= 1'b0;
         tc_seen_q <= 1'b0;
         ecc_q <= ECC_INIT;
         rdata_q <= 8'h00;
         sel_q <= 1'b0;
         go_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cmd_q <= cmd_d;
         ctrl_q <= ctrl_d;
         busy_q <= busy_d;
         sense_q <= sense_d;
         dir_q <= dir_d;
         err_q <= err_d;
         sense_bytes_q <= sense_bytes_d;
         rec_q <= rec_d;
         full_q <= full_d;
         tc_seen_q <= tc_seen_d;
         ecc_q <= ecc_d;
         rdata_q <= rdata_d;
         sel_q <= sel_d;
         go_q <= go_d;
         irq_q <= irq_d;
      end
   end

   // Status, data and control ports read back controller state
   assign io_rdata_o = rdata_q;
   assign ctl_sel_o = sel_q;
   assign cmd_go_o = go_q;
   assign cmd_o = cmd_q;
   assign irq_o = irq_q;
   assign rec_out_data_o = rec_q;
   assign ecc_o = ecc_q;
   // Shared cable: unit bit picks one of two drives
   assign drive_sel_o = lun ? 2'h2 : 2'h1;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   a_sel_pulse: assert property (io_i.wr && hit(io_i, PORT_SEL)
      |=> ctl_sel_o ##1 !ctl_sel_o) else $error("select pulse wrong");
   a_stat_read: assert property (io_i.rd && hit(io_i, PORT_STAT)
      |=> io_rdata_o == $past(status_w)) else $error("status read wrong");
   a_compl_fmt: assert property (rd_data && state_q == ST_STATB
      |=> (io_rdata_o & 8'hDD) == 8'h00 && io_rdata_o[1] == $past(err_q))
      else $error("completion byte bad");
   a_busy_drop: assert property (rd_data && state_q == ST_STATB
      && !io_i.wr |=> !busy_q && !status_w[ST_BUSY])
      else $error("busy not dropped");
   a_irq_raise: assert property (state_q == ST_STATB && ctrl_q[0]
      |-> irq_o) else $error("irq missing");
   a_sense_follow: assert property (rd_data && state_q == ST_STATB
      && err_q && !io_i.wr |=> sense_q && cnt_q == 3'h0)
      else $error("sense not offered");
   a_cmd_go: assert property (wr_data && state_q == ST_CMDIN
      && cnt_q == 3'h5 |=> cmd_go_o && state_q == ST_WAIT)
      else $error("go missing");
   a_dma_read: assert property (state_q == ST_XFER && dir_q
      && dack_i && io_i.rd && !rec_in_valid_i && !core_done_i
      |=> !full_q && io_rdata_o == $past(rec_q)) else $error("dma read");
   a_drive_one: assert property ($onehot(drive_sel_o))
      else $error("drive select");
   a_stat_ro: assert property (io_i.wr && hit(io_i, PORT_STAT)
      && state_q == ST_IDLE |=> state_q == ST_IDLE)
      else $error("status write had effect");
   a_busy_set: assert property (io_i.wr && hit(io_i, PORT_SEL)
      |=> status_w[ST_BUSY] && status_w[ST_CMD])
      else $error("busy not set");
   a_irq_clear: assert property (rd_data && state_q == ST_STATB
      |=> !irq_o) else $error("irq not cleared");

   // DMA side; a request must fall once its byte or the count is done
   a_ecc_step: assert property (rec_in_valid_i && rec_in_ready_o
      && !io_i.wr |=> ecc_o == ecc_step($past(ecc_q), $past(rec_in_data_i)))
      else $error("ecc not updated");
   a_tc_stop: assert property (state_q == ST_XFER && dack_i && tc_i
      |=> !drq_o) else $error("request after count");
   a_drq_gate: assert property (drq_o
      |-> state_q == ST_XFER && ctrl_q[CT_DMA_EN])
      else $error("stray request");

   // Scenarios the bench is expected to reach
   c_xfer: cover property (state_q == ST_XFER ##[1:600] state_q == ST_STATB);
   c_sense: cover property (sense_q && cnt_q == 3'h3);
   c_go: cover property (cmd_go_o);
   c_tc: cover property (tc_seen_q && state_q == ST_XFER);
   c_irq: cover property (irq_o && status_w[ST_DIR]);
endmodule

// file: test/core_model.sv
/*
 Behavioural disk controller core seen behind the host port.
 Assumes the bench sets the mode inputs before the command starts.
*/
`timescale 1ns/1ns
module core_model (
   input wire logic sys_clk_i,
   input wire logic go_i,
   input wire logic xfer_en_i,
   input wire logic err_i,
   input wire logic [7:0] byte_i,
   input wire logic [31:0] sense_i,
   input wire logic rdy_i,
   output logic xfer_o,
   output logic done_o,
   output disk_port_pkg::core_done_s res_o,
   output logic vld_o,
   output logic [7:0] data_o
);
   import disk_port_pkg::*;
   logic ok;
   // Bounded wait for room at the port; gives up after 100 cycles
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(negedge sys_clk_i);
         ok = rdy_i;
         n++;
         @(posedge sys_clk_i);
      end while (!ok && n < 100);
   endtask
   initial begin
      {xfer_o, done_o, vld_o, ok} = 4'h0;
      res_o = '0;
      data_o = 8'h00;
      forever begin
         @(negedge sys_clk_i);
         if (go_i) begin
            repeat (3) @(posedge sys_clk_i);
            if (xfer_en_i) begin
               xfer_o <= 1'b1;
               @(posedge sys_clk_i);
               xfer_o <= 1'b0;
               vld_o <= 1'b1;
               data_o <= byte_i;
               wait_rdy();
               vld_o <= 1'b0;
               // Stale byte inverted so it never passes for fresh data
               data_o <= ~byte_i;
               // Command ends once the host has drained the byte or after 100 cycles
               wait_rdy();
            end
            // Zero ECC: mismatches any nonzero record byte
            res_o <= '{err: err_i, ecc: 32'h00000000, sense: sense_i};
            done_o <= 1'b1;
            @(posedge sys_clk_i);
            done_o <= 1'b0;
         end
      end
   end
endmodule

// file: test/tb.sv
/*
 Self-checking bench for the disk host port.
 Assumes the port map and status bits of disk_port_pkg.
*/
`timescale 1ns/1ns
module tb;
   import disk_port_pkg::*;
   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   io_req_s io = '0;
   logic dack = 1'b0;
   logic go, irq, drq, sel, xfer, done, vld, rdy, xen = 1'b0, err = 1'b0;
   logic tc = 1'b0;
   logic [7:0] rdata, rbyte = 8'h5A, d, rin;
   logic [31:0] sense = 32'hA1B2C3D4, ecc;
   logic [47:0] cmd;
   logic [1:0] dsel;
   core_done_s res;
   int err_total = 0, comparisons = 0, n;

   always #2 sys_clk_i = ~sys_clk_i;

   disk_host_port disk_host_port_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .io_i(io), .io_rdata_o(rdata), .dack_i(dack), .tc_i(tc),
      .drq_o(drq), .irq_o(irq), .ctl_sel_o(sel), .cmd_go_o(go), .cmd_o(cmd),
      .core_xfer_i(xfer), .core_dir_i(1'b1), .core_done_i(done),
      .core_res_i(res), .rec_in_valid_i(vld), .rec_in_data_i(rin),
      .rec_in_ready_o(rdy), .rec_out_valid_o(), .rec_out_data_o(),
      .rec_out_ready_i(1'b1), .ecc_o(ecc), .drive_sel_o(dsel));
   core_model core_model_i (.sys_clk_i(sys_clk_i), .go_i(go),
      .xfer_en_i(xen), .err_i(err), .byte_i(rbyte), .sense_i(sense),
      .rdy_i(rdy), .xfer_o(xfer), .done_o(done), .res_o(res), .vld_o(vld),
      .data_o(rin));

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [47:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic io_wr(input logic [9:0] a, input logic [7:0] v);
      @(negedge sys_clk_i);
      io.wr = 1'b1;
      io.addr = a;
      io.wdata = v;
      @(negedge sys_clk_i);
      io.wr = 1'b0;
   endtask
   // DMA reads ignore the port decode, so dm selects the cycle kind
   task automatic io_rd(input logic [9:0] a, input logic dm,
                        output logic [7:0] v);
      @(negedge sys_clk_i);
      io.rd = 1'b1;
      io.addr = a;
      dack = dm;
      tc = dm;
      @(negedge sys_clk_i);
      io.rd = 1'b0;
      dack = 1'b0;
      tc = 1'b0;
      v = rdata;
   endtask
   task automatic start_cmd(input logic [7:0] b1);
      logic [47:0] exp;
      io_wr(PORT_SEL, 8'h00);
      chk("select", 1, sel);
      io_rd(PORT_STAT, 1'b0, d);
      chk("status_cmd", 8'h0D, d);
      for (int i = 0; i < 6; i++) begin
         exp[47-8*i -: 8] = (i == 1) ? b1 : 8'h10 + 8'(i);
         io_wr(PORT_DATA, exp[47-8*i -: 8]);
      end
      chk("cmd_go", 1, go);
      chk("cmd_bytes", exp, cmd);
      chk("drive_sel", b1[5] ? 2'h2 : 2'h1, dsel);
   endtask
   task automatic end_cmd(input logic [7:0] cb);
      n = 0;
      do begin
         io_rd(PORT_STAT, 1'b0, d);
         n++;
      end while (!(d[ST_REQ] && d[ST_DIR]) && n < 200);
      if (!(d[ST_REQ] && d[ST_DIR])) begin
         err_total++;
         test_done();
      end
      chk("irq_on", 1, irq);
      io_rd(PORT_DATA, 1'b0, d);
      chk("completion", cb, d);
      io_rd(PORT_STAT, 1'b0, d);
      chk("busy_off", 0, d[ST_BUSY]);
      chk("irq_off", 0, irq);
   endtask

   initial begin
      repeat (6) @(negedge sys_clk_i);
      srst_i = 1'b0;
      io_rd(PORT_STAT, 1'b0, d);
      chk("status_rst", 8'h00, d);
      io_wr(PORT_STAT, 8'hFF);
      io_rd(PORT_STAT, 1'b0, d);
      chk("status_ro", 8'h00, d);
      io_rd(10'h3FF, 1'b0, d);
      chk("unmapped", 8'h00, d);
      io_rd(PORT_DATA, 1'b0, d);
      chk("data_idle", 8'h00, d);
      io_wr(PORT_CTRL, 8'h03);
      $display("test registers done");
      start_cmd(8'h00);
      end_cmd(8'h00);
      $display("test plain command done");
      err = 1'b1;
      start_cmd(8'h20);
      end_cmd(8'h22);
      for (int i = 0; i < 4; i++) begin
         io_rd(PORT_DATA, 1'b0, d);
         chk("sense", sense[31-8*i -: 8], d);
      end
      $display("test error sense done");
      err = 1'b0;
      xen = 1'b1;
      start_cmd(8'h00);
      n = 0;
      while (!drq && n < 200) begin
         @(negedge sys_clk_i);
         n++;
      end
      chk("drq", 1, drq);
      if (!drq) begin
         test_done();
      end
      io_rd(10'h000, 1'b1, d);
      chk("dma_byte", rbyte, d);
      chk("ecc", 32'h571D7DD1, ecc);
      chk("drq_off", 0, drq);
      end_cmd(8'h02);
      io_rd(PORT_DATA, 1'b0, d);
      chk("ecc_sense", SENSE_DATA_ERR, d);
      $display("test dma ecc done");
      test_done();
   end
endmodule
